// file: verilog/lscc_regs.sv
// Register bank for dark-level backlight codes, sink fade law and sink enables.
// Assumes a single AHB-Lite master; hready is this slave's own hreadyout.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Dark max register holds 7-bit current code in bits 6:0, bit 7 reserved.
// - Code 0 is zero current, 1 is 0.236/0.002 mA, all ones 30 mA.
// - Dark dim code in bits 6:0 drives backlight when dim enable is set.
// - Dim code is also applied after a dim timeout expires.
// - Two-bit fade law in bits 1:0 selects DAC law and time steps.
// - Sink enable register holds seven enables in bits 0..6, bit 7 reserved.
// - Writing 1 turns that sink on, writing 0 turns it off.
module lscc_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Dim timeout expiry from the timer logic
  input wire logic dim_timeout,
  // Targets to the sink and DAC logic
  output lscc_pkg::lscc_target_s bl_target,
  output logic [6:0] sink_on,
  output logic [1:0] sink_fade_law_sel
);
  import lscc_pkg::*;

  lscc_aphase_s aph_reg, aph_next;
  logic [6:0] dark_max_code_reg, dark_max_code_next;
  logic [6:0] dark_dim_code_reg, dark_dim_code_next;
  logic [1:0] law_reg, law_next;
  logic [6:0] sink_reg, sink_next;
  logic dim_en_reg, dim_en_next;
  logic [31:0] rdata_reg, rdata_next;
  lscc_target_s tgt_comb;
  lscc_target_s tgt_reg;
  logic ready_reg, ready_next;
  logic resp_reg, resp_next;

  // Word index from a byte address; upper bits must be zero to hit
  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic addr_hits(input logic [31:0] addr);
    addr_hits = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'b00);
  endfunction

  // Mapped word indices; anything else reads zero and ignores writes
  function automatic logic idx_mapped(input logic [7:0] idx);
    case (idx)
      LSCC_IDX_DARK_MAX, LSCC_IDX_DARK_DIM, LSCC_IDX_FADE_LAW,
      LSCC_IDX_SINK_EN, LSCC_IDX_DIM_CTRL, LSCC_IDX_STATUS: idx_mapped = 1'b1;
      default: idx_mapped = 1'b0;
    endcase
  endfunction

  lscc_sel u_sel (
    .max_code(dark_max_code_reg),
    .dim_code(dark_dim_code_reg),
    .law(law_reg),
    .dim_en(dim_en_reg),
    .dim_timeout(dim_timeout),
    .target(tgt_comb)
  );

  // Address phase capture; zero wait states, so every phase is accepted
  always_comb begin
    aph_next.valid = hsel & hready & htrans[1] & addr_hits(haddr);
    aph_next.write = hwrite;
    aph_next.index = word_index(haddr);
  end

  // Register writes in the data phase; read data registered at the same edge
  always_comb begin
    dark_max_code_next = dark_max_code_reg;
    dark_dim_code_next = dark_dim_code_reg;
    law_next = law_reg;
    sink_next = sink_reg;
    dim_en_next = dim_en_reg;
    if (aph_reg.valid && aph_reg.write) begin
      case (aph_reg.index)
        LSCC_IDX_DARK_MAX: dark_max_code_next = hwdata[6:0];
        LSCC_IDX_DARK_DIM: dark_dim_code_next = hwdata[6:0];
        LSCC_IDX_FADE_LAW: law_next = hwdata[1:0];
        LSCC_IDX_SINK_EN: sink_next = hwdata[6:0];
        LSCC_IDX_DIM_CTRL: dim_en_next = hwdata[LSCC_DIMEN_BIT];
        default: begin
        end
      endcase
    end
  end

  // Read mux for the next address phase; zero fill keeps reserved bits clear
  always_comb begin
    rdata_next = 32'h00000000;
    if (aph_next.valid && !hwrite) begin
      case (aph_next.index)
        LSCC_IDX_DARK_MAX: rdata_next = {25'h0000000, dark_max_code_next};
        LSCC_IDX_DARK_DIM: rdata_next = {25'h0000000, dark_dim_code_next};
        LSCC_IDX_FADE_LAW: rdata_next = {30'h00000000, law_next};
        LSCC_IDX_SINK_EN: rdata_next = {25'h0000000, sink_next};
        LSCC_IDX_DIM_CTRL: rdata_next = {31'h00000000, dim_en_next};
        LSCC_IDX_STATUS: rdata_next = {22'h000000, tgt_comb.dimmed, dim_timeout,
                                       1'b0, tgt_comb.code};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Bus response; constant zero wait and OKAY, registered so the pins come from flops
  always_comb begin
    ready_next = 1'b1;
    resp_next = 1'b0;
  end

  // State registers
  always_ff @(posedge clock) begin
    if (rst) begin
      aph_reg <= '0;
      dark_max_code_reg <= LSCC_CODE_RST;
      dark_dim_code_reg <= LSCC_CODE_RST;
      law_reg <= LSCC_LAW_RST;
      sink_reg <= LSCC_SINK_RST;
      dim_en_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      tgt_reg <= '0;
      ready_reg <= 1'b1;
      resp_reg <= 1'b0;
    end else begin
      aph_reg <= aph_next;
      dark_max_code_reg <= dark_max_code_next;
      dark_dim_code_reg <= dark_dim_code_next;
      law_reg <= law_next;
      sink_reg <= sink_next;
      dim_en_reg <= dim_en_next;
      rdata_reg <= rdata_next;
      tgt_reg <= tgt_comb;
      ready_reg <= ready_next;
      resp_reg <= resp_next;
    end
  end

  // Outputs straight from flops; slave never stalls and always answers OKAY
  assign hrdata = rdata_reg;
  assign hreadyout = ready_reg;
  assign hresp = resp_reg;
  assign bl_target = tgt_reg;
  assign sink_on = sink_reg;
  assign sink_fade_law_sel = law_reg;

  // Assertions
  chk_sink_write: assert property (@(posedge clock) disable iff (rst)
    (aph_reg.valid && aph_reg.write && aph_reg.index == LSCC_IDX_SINK_EN)
    |=> sink_on == $past(hwdata[6:0]))
    else $error("sink enables did not follow write");
  chk_dim_select: assert property (@(posedge clock) disable iff (rst)
    dim_en_reg |=> bl_target.code == $past(dark_dim_code_reg))
    else $error("dim code not applied with dim enable");
  chk_timeout_dim: assert property (@(posedge clock) disable iff (rst)
    dim_timeout |=> bl_target.dimmed && bl_target.code == $past(dark_dim_code_reg))
    else $error("dim code not applied after timeout");
  chk_max_select: assert property (@(posedge clock) disable iff (rst)
    (!dim_en_reg && !dim_timeout) |=> bl_target.code == $past(dark_max_code_reg))
    else $error("max code not applied when not dimmed");
  chk_law_dac: assert property (@(posedge clock) disable iff (rst)
    1'b1 |-> bl_target.square_law == (bl_target.law != 2'b00))
    else $error("dac law tag mismatch");
  chk_law_write: assert property (@(posedge clock) disable iff (rst)
    (aph_reg.valid && aph_reg.write && aph_reg.index == LSCC_IDX_FADE_LAW)
    |=> sink_fade_law_sel == $past(hwdata[1:0]) ##1 bl_target.law == $past(law_reg))
    else $error("fade law did not follow write");
  chk_resv_read: assert property (@(posedge clock) disable iff (rst)
    (aph_next.valid && !hwrite && aph_next.index == LSCC_IDX_FADE_LAW)
    |=> hrdata[31:2] == 30'h00000000)
    else $error("reserved fade law bits read nonzero");
  chk_sink_read: assert property (@(posedge clock) disable iff (rst)
    (aph_next.valid && !hwrite && aph_next.index == LSCC_IDX_SINK_EN)
    |=> hrdata == {25'h0000000, sink_on})
    else $error("sink enable readback wrong");
  chk_max_read: assert property (@(posedge clock) disable iff (rst)
    (aph_next.valid && !hwrite && aph_next.index == LSCC_IDX_DARK_MAX)
    |=> hrdata[31:7] == 25'h0000000)
    else $error("dark max reserved bits read nonzero");
  chk_max_write: assert property (@(posedge clock) disable iff (rst)
    (aph_reg.valid && aph_reg.write && aph_reg.index == LSCC_IDX_DARK_MAX)
    |=> dark_max_code_reg == $past(hwdata[6:0]))
    else $error("dark max code did not follow write");
  chk_dim_write: assert property (@(posedge clock) disable iff (rst)
    (aph_reg.valid && aph_reg.write && aph_reg.index == LSCC_IDX_DARK_DIM)
    |=> dark_dim_code_reg == $past(hwdata[6:0]))
    else $error("dark dim code did not follow write");
  chk_dim_read: assert property (@(posedge clock) disable iff (rst)
    (aph_next.valid && !hwrite && aph_next.index == LSCC_IDX_DARK_DIM)
    |=> hrdata == {25'h0000000, dark_dim_code_reg})
    else $error("dark dim readback wrong");
  chk_law_read: assert property (@(posedge clock) disable iff (rst)
    (aph_next.valid && !hwrite && aph_next.index == LSCC_IDX_FADE_LAW)
    |=> hrdata == {30'h00000000, sink_fade_law_sel})
    else $error("fade law readback wrong");
  chk_unmapped_read: assert property (@(posedge clock) disable iff (rst)
    (aph_next.valid && !hwrite && !idx_mapped(aph_next.index))
    |=> hrdata == 32'h00000000)
    else $error("unmapped word read nonzero");
  chk_idle_rdata: assert property (@(posedge clock) disable iff (rst)
    !(aph_next.valid && !hwrite)
    |=> hrdata == 32'h00000000)
    else $error("read data not zero outside a read data phase");

  cov_sink_all_on: cover property (@(posedge clock) disable iff (rst) sink_on == 7'h7F);
  cov_timeout_dim: cover property (@(posedge clock) disable iff (rst)
    dim_timeout && !dim_en_reg);
  cov_cubic_law: cover property (@(posedge clock) disable iff (rst)
    sink_fade_law_sel == 2'b11);
  cov_dim_enable: cover property (@(posedge clock) disable iff (rst) dim_en_reg && !dim_timeout);
endmodule
`default_nettype wire

// file: include/lscc_pkg.sv
// Package for the dark-level backlight and sink enable register bank.
// Assumes an AHB-Lite slave with 32-bit data, one register per word.
package lscc_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] LSCC_IDX_DARK_MAX = 8'h0D;
  localparam logic [7:0] LSCC_IDX_DARK_DIM = 8'h0E;
  localparam logic [7:0] LSCC_IDX_FADE_LAW = 8'h0F;
  localparam logic [7:0] LSCC_IDX_SINK_EN = 8'h10;
  // Control register holding the dim enable flag in bit 0; the dim timeout flag reads back in the status register
  localparam logic [7:0] LSCC_IDX_DIM_CTRL = 8'h20;
  // Status register showing the applied backlight code and dim state
  localparam logic [7:0] LSCC_IDX_STATUS = 8'h21;

  // Field layouts
  localparam int LSCC_CODE_W = 7;
  localparam int LSCC_LAW_W = 2;
  localparam int LSCC_SINKS = 7;
  localparam int LSCC_DIMEN_BIT = 0;
  localparam int LSCC_DIMTO_BIT = 1;

  // Reset values
  localparam logic [6:0] LSCC_CODE_RST = 7'h00;
  localparam logic [1:0] LSCC_LAW_RST = 2'h0;
  localparam logic [6:0] LSCC_SINK_RST = 7'h00;

  // Fade transfer laws
  typedef enum logic [1:0] {
    LSCC_LAW_LIN_LIN = 2'b00,
    LSCC_LAW_SQ_LIN = 2'b01,
    LSCC_LAW_SQ_CUBIC10 = 2'b10,
    LSCC_LAW_SQ_CUBIC11 = 2'b11
  } lscc_law_e;

  // Current target handed to the sink DAC logic
  typedef struct packed {
    logic [6:0] code;
    logic square_law;
    logic [1:0] law;
    logic dimmed;
  } lscc_target_s;

  // Captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] index;
  } lscc_aphase_s;

endpackage

// file: verilog/lscc_sel.sv
// Backlight current selector: picks max or dim code and tags the DAC law.
// Assumes all inputs are register outputs of the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module lscc_sel (
  // Codes and law
  input wire logic [6:0] max_code,
  input wire logic [6:0] dim_code,
  input wire logic [1:0] law,
  // Dim requests
  input wire logic dim_en,
  input wire logic dim_timeout,
  // Selected target
  output lscc_pkg::lscc_target_s target
);
  import lscc_pkg::*;

  // Dim code wins when either dim source asks for it
  always_comb begin
    target.dimmed = dim_en | dim_timeout;
    target.code = target.dimmed ? dim_code : max_code;
    // Only law 00 uses the linear DAC; code 1 is then 0.236 mA
    target.square_law = (law != LSCC_LAW_LIN_LIN);
    target.law = law;
  end
endmodule
`default_nettype wire

// file: dv/lscc_regs_tb.sv
// Self-checking bench for the dark-level current and sink enable register bank.
// Drives the AHB-Lite slave itself; a small register model predicts every result.
`timescale 1ns/1ps
`default_nettype none
module lscc_regs_tb;
  import lscc_pkg::*;
  localparam logic [31:0] A_MAX = {22'h0, LSCC_IDX_DARK_MAX, 2'b00};
  localparam logic [31:0] A_DIM = {22'h0, LSCC_IDX_DARK_DIM, 2'b00};
  localparam logic [31:0] A_LAW = {22'h0, LSCC_IDX_FADE_LAW, 2'b00};
  localparam logic [31:0] A_SINK = {22'h0, LSCC_IDX_SINK_EN, 2'b00};
  localparam logic [31:0] A_CTRL = {22'h0, LSCC_IDX_DIM_CTRL, 2'b00};
  localparam logic [31:0] A_STAT = {22'h0, LSCC_IDX_STATUS, 2'b00};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic dim_timeout = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  lscc_target_s bl_target;
  logic [6:0] sink_on;
  logic [1:0] sink_fade_law_sel;
  logic [31:0] addrs [7];
  logic [6:0] mmax = 7'h00;
  logic [6:0] mdim = 7'h00;
  logic [6:0] msink = 7'h00;
  logic [1:0] mlaw = 2'h0;
  logic mden = 1'b0;
  int n_mismatch = 0;
  int tests_run = 0;
  integer seed = 32'h948A77B8;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  lscc_regs i_lscc_regs (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dim_timeout(dim_timeout),
    .bl_target(bl_target), .sink_on(sink_on), .sink_fade_law_sel(sink_fade_law_sel));

  // Model read value; dim is chosen by the enable or by an expired timeout
  function automatic logic [31:0] erd(input logic [31:0] a);
    logic dm;
    dm = mden | dim_timeout;
    case (a)
      A_MAX: return {25'h0, mmax};
      A_DIM: return {25'h0, mdim};
      A_LAW: return {30'h0, mlaw};
      A_SINK: return {25'h0, msink};
      A_CTRL: return {31'h0, mden};
      A_STAT: return {22'h0, dm, dim_timeout, 1'b0, dm ? mdim : mmax};
      default: return 32'h0;
    endcase
  endfunction

  // Model target: every law except 00 uses the square DAC
  function automatic lscc_target_s etgt();
    logic dm;
    dm = mden | dim_timeout;
    return lscc_target_s'({dm ? mdim : mmax, mlaw != 2'h0, mlaw, dm});
  endfunction

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [21:0] got, input logic [21:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: outputs %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; waits on ready, never assumes a latency.
  // Called at a rising edge; read data is taken at the edge that ends the data phase.
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Write, read back, read status, then compare the sink side outputs
  task automatic step(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    dim_timeout <= 1'($random(seed));
    bus(a, 1'b1, d, r);
    case (a)
      A_MAX: mmax = d[6:0];
      A_DIM: mdim = d[6:0];
      A_LAW: mlaw = d[1:0];
      A_SINK: msink = d[6:0];
      A_CTRL: mden = d[0];
      default: ;
    endcase
    bus(a, 1'b0, 32'h0, r);
    chk_rd(r, erd(a));
    bus(A_STAT, 1'b0, 32'h0, r);
    chk_rd(r, erd(A_STAT));
    chk_out({hresp, hreadyout, bl_target, sink_on, sink_fade_law_sel},
            {1'b0, 1'b1, etgt(), msink, mlaw});
  endtask

  // Read every register and one unmapped word against the model
  task automatic read_all;
    logic [31:0] r;
    for (int k = 0; k < 7; k++) begin
      bus(addrs[k], 1'b0, 32'h0, r);
      chk_rd(r, erd(addrs[k]));
    end
  endtask

  task automatic results;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    results;
  end

  initial begin
    addrs = '{A_MAX, A_DIM, A_LAW, A_SINK, A_CTRL, A_STAT, 32'h0000_0100};
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    read_all();
    // Every fade law, with the reserved bits scrambled
    for (int j = 0; j < 4; j++) begin
      step(A_LAW, {30'($random(seed)), 2'(j)});
    end
    // Walking one over the sinks, then reserved bits alone
    for (int j = 0; j < 7; j++) begin
      step(A_SINK, 32'h1 << j);
    end
    step(A_SINK, 32'hFFFF_FF80);
    step(A_MAX, 32'hFFFF_FFFF);
    step(A_DIM, 32'h0000_0001);
    step(A_CTRL, 32'h0000_0001);
    step(A_CTRL, 32'h0000_0000);
    // Mid-run reset must clear every register again
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    mmax = 7'h00;
    mdim = 7'h00;
    msink = 7'h00;
    mlaw = 2'h0;
    mden = 1'b0;
    read_all();
    for (int i = 0; i < 40; i++) begin
      step(addrs[$unsigned($random(seed)) % 7], $random(seed));
    end
    results;
  end
endmodule
`default_nettype wire
